// [rtl/dsbe_decode.sv]
// opcode decoder for the decrement / skip / branch execute block
// assumes a 14-bit instruction word already marked valid by the caller
`timescale 1ns/10ps
module dsbe_decode
  import dsbe_pkg::*;
(
  input  wire logic [DSBE_IW-1:0] instr,
  output logic                    is_dec,
  output logic                    is_decskip,
  output logic                    is_branch,
  output logic                    dest_reg,
  output logic [DSBE_AW-1:0]      reg_addr,
  output logic [DSBE_KW-1:0]      target
);
  // field pulls are pure wiring; the main module registers the effects
  assign is_dec     = (instr[13:8] == DSBE_OP_DEC);
  assign is_decskip = (instr[13:8] == DSBE_OP_DECSKIP);
  assign is_branch  = (instr[13:11] == DSBE_OP_BRANCH);
  assign dest_reg   = instr[DSBE_DEST_BIT];
  assign reg_addr   = instr[DSBE_AW-1:0];
  assign target     = instr[DSBE_KW-1:0];
endmodule

// [rtl/dsbe_exec.sv]
// execute stage for decrement, decrement-and-skip and unconditional branch
// assumes the fetch stage presents one instruction per cycle with instr_valid,
// a combinational register file read port, and honours flush and pc_load
// the write-back is registered, so a pending write is forwarded to the next
// instruction; the register file never has to write through to its read port
// the program counter itself lives in the fetch stage: this block only
// hands it a new value with a one-cycle load pulse
//
// Overview of operation
// - decode decrement opcode, bit 7 selects destination, low 7 bits address
// - destination select 0 writes accumulator, 1 writes the data register
// - decode decrement-and-skip, steer result by destination, flags untouched
// - zero skip result squashes the prefetched instruction into a no-op
// - decrement-and-skip takes one cycle, or two when the skip happens
// - decode unconditional branch, low eleven bits are target, flags untouched
// - branch loads eleven-bit immediate into program counter bits 10 to 0
// - branch takes program counter bits 12 and 11 from latch bits 4 and 3
// - branch takes two cycles, second flushes the sequentially fetched word
`timescale 1ns/10ps
module dsbe_exec
  import dsbe_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                instr_valid,
  input  wire logic [DSBE_IW-1:0]  instr,
  input  wire logic [DSBE_DW-1:0]  program_counter_high_latch,
  input  wire logic [DSBE_DW-1:0]  rf_rdata,
  output logic [DSBE_AW-1:0]       rf_raddr,
  output logic                     rf_we,
  output logic [DSBE_AW-1:0]       rf_waddr,
  output logic [DSBE_DW-1:0]       rf_wdata,
  output logic [DSBE_DW-1:0]       acc,
  output logic                     zero_flag,
  output logic                     pc_load,
  output logic [DSBE_PCW-1:0]      pc_target,
  output logic                     flush,
  output logic                     busy
);
  typedef enum logic [0:0] {DSBE_RUN, DSBE_BUBBLE} dsbe_state_e;

  logic                is_dec;
  logic                is_decskip;
  logic                is_branch;
  logic                dest_reg;
  logic [DSBE_AW-1:0]  reg_addr;
  logic [DSBE_KW-1:0]  target;
  dsbe_state_e         state_r;
  dsbe_state_e         state_nxt;
  logic [DSBE_DW-1:0]  acc_r;
  logic [DSBE_DW-1:0]  acc_nxt;
  logic                zflag_r;
  logic                zflag_nxt;
  logic                rf_we_r;
  logic [DSBE_AW-1:0]  rf_waddr_r;
  logic [DSBE_DW-1:0]  rf_wdata_r;
  logic                pc_load_r;
  logic [DSBE_PCW-1:0] pc_target_r;
  logic                rf_we_nxt;
  logic [DSBE_AW-1:0]  rf_waddr_nxt;
  logic [DSBE_DW-1:0]  rf_wdata_nxt;
  logic                pc_load_nxt;
  logic [DSBE_PCW-1:0] pc_target_nxt;

  dsbe_decode u_decode (
    .instr      (instr),
    .is_dec     (is_dec),
    .is_decskip (is_decskip),
    .is_branch  (is_branch),
    .dest_reg   (dest_reg),
    .reg_addr   (reg_addr),
    .target     (target)
  );

  // an instruction only executes when valid and not in a flushed slot
  wire           exec_ok  = instr_valid && (state_r == DSBE_RUN);
  wire           do_dec   = exec_ok && is_dec;
  wire           do_skip  = exec_ok && is_decskip;
  wire           do_brn   = exec_ok && is_branch;
  wire           any_dec  = do_dec || do_skip;
  // a write still in its register has not reached the file yet, so the
  // instruction right behind it takes the pending value instead
  wire           fwd_hit  = rf_we_r && (rf_waddr_r == reg_addr);
  wire [DSBE_DW-1:0] src_val = fwd_hit ? rf_wdata_r : rf_rdata;
  wire [DSBE_DW-1:0] dec_res = src_val - 8'h01;
  wire           res_zero = (dec_res == DSBE_ZERO_RST);
  wire           skip_hit = do_skip && res_zero;
  wire [DSBE_PCW-1:0] brn_pc = {program_counter_high_latch[DSBE_LATCH_HI:
                                 DSBE_LATCH_LO], target};

  assign rf_raddr = reg_addr;

  // destination steering: d=0 accumulator, d=1 register file
  assign acc_nxt   = (any_dec && !dest_reg) ? dec_res : acc_r;
  // only the plain decrement touches the zero flag
  assign zflag_nxt = do_dec ? res_zero : zflag_r;
  // a zero-result skip and a branch both spend one extra cycle as a no-op bubble
  assign state_nxt = (skip_hit || do_brn) ? DSBE_BUBBLE : DSBE_RUN;

  // write-back and branch requests, named so the flops below stay plain
  assign rf_we_nxt     = any_dec && dest_reg;
  assign rf_waddr_nxt  = reg_addr;
  assign rf_wdata_nxt  = dec_res;
  assign pc_load_nxt   = do_brn;
  // the target holds after the pulse so the fetch stage may sample it late
  assign pc_target_nxt = do_brn ? brn_pc : pc_target_r;

  // sequencing state; the bubble lasts exactly one cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= DSBE_RUN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // architectural results: accumulator and zero flag
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      acc_r   <= DSBE_ACC_RST;
      zflag_r <= DSBE_ZFLAG_RST;
    end
    else
    begin
      acc_r   <= acc_nxt;
      zflag_r <= zflag_nxt;
    end
  end

  // register file write-back, one-cycle strobe with address and data
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rf_we_r    <= 1'b0;
      rf_waddr_r <= '0;
      rf_wdata_r <= DSBE_ZERO_RST;
    end
    else
    begin
      rf_we_r    <= rf_we_nxt;
      rf_waddr_r <= rf_waddr_nxt;
      rf_wdata_r <= rf_wdata_nxt;
    end
  end

  // program counter load request towards the fetch stage
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pc_load_r   <= 1'b0;
      pc_target_r <= DSBE_PC_RST;
    end
    else
    begin
      pc_load_r   <= pc_load_nxt;
      pc_target_r <= pc_target_nxt;
    end
  end

  // flush covers the bubble slot: the prefetched word is discarded
  assign flush     = (state_r == DSBE_BUBBLE);
  assign busy      = flush;
  assign acc       = acc_r;
  assign zero_flag = zflag_r;
  assign rf_we     = rf_we_r;
  assign rf_waddr  = rf_waddr_r;
  assign rf_wdata  = rf_wdata_r;
  assign pc_load   = pc_load_r;
  assign pc_target = pc_target_r;

  // reference view of the addressed register as the rules see it: the
  // pending write-back if it targets this address, else the file's word
  wire [DSBE_DW-1:0] reg_now = (rf_we && (rf_waddr == rf_raddr)) ?
                               rf_wdata : rf_rdata;

  // checks on the observable results, one cycle after the taking edge
  a_dec_acc_write: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    do_dec && !dest_reg |=> acc == $past(reg_now) - 8'h01 && !rf_we)
    else $error("decrement to accumulator wrong");
  a_dec_zero_flag: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    do_dec |=> zero_flag == ($past(reg_now) == 8'h01))
    else $error("zero flag wrong after decrement");
  a_dec_one_cycle: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    do_dec |=> !flush)
    else $error("plain decrement stalled the pipe");
  a_skip_flags_kept: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (do_skip || do_brn) |=> $stable(zero_flag))
    else $error("skip or branch changed zero flag");
  a_skip_reg_write: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    do_skip && dest_reg |=> rf_we && rf_wdata == $past(reg_now) - 8'h01)
    else $error("skip write-back missing");
  a_waddr_match: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    any_dec && dest_reg |=> rf_waddr == $past(instr[DSBE_AW-1:0]))
    else $error("write-back address wrong");
  a_skip_flushes: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    do_skip && reg_now == 8'h01 |=> flush ##1 !flush)
    else $error("zero skip did not squash one slot");
  a_noskip_one_cyc: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    do_skip && reg_now != 8'h01 |=> !flush)
    else $error("nonzero skip took two cycles");
  a_branch_target: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    do_brn |=> pc_load && pc_target[10:0] == $past(instr[10:0])
      && pc_target[12:11] == $past(program_counter_high_latch[4:3]))
    else $error("branch target wrong");
  a_branch_two_cyc: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    do_brn |=> flush && pc_load ##1 !flush && !pc_load)
    else $error("branch not two cycles");
  // the squashed slot must leave no trace in any result
  a_bubble_no_effect: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    flush |=> !rf_we && !pc_load && $stable(acc) && $stable(zero_flag))
    else $error("squashed slot changed a result");
endmodule

// [rtl/dsbe_pkg.sv]
// package for the decrement / skip / branch execute block
// assumes an 8-bit data path, 7-bit register address, 13-bit program counter
package dsbe_pkg;
  localparam int          DSBE_IW          = 14;
  localparam int          DSBE_DW          = 8;
  localparam int          DSBE_AW          = 7;
  localparam int          DSBE_PCW         = 13;
  localparam int          DSBE_KW          = 11;
  // opcode patterns: top bits of the word compared against these
  localparam logic [5:0]  DSBE_OP_DEC      = 6'h03;
  localparam logic [5:0]  DSBE_OP_DECSKIP  = 6'h0B;
  localparam logic [2:0]  DSBE_OP_BRANCH   = 3'h5;
  localparam int          DSBE_DEST_BIT    = 7;
  localparam int          DSBE_LATCH_LO    = 3;
  localparam int          DSBE_LATCH_HI    = 4;
  localparam logic [7:0]  DSBE_ZERO_RST    = 8'h00;
  // the core clears to zero after reset
  localparam logic [12:0] DSBE_PC_RST      = 13'h0000;
  localparam logic [7:0]  DSBE_ACC_RST     = 8'h00;
  localparam logic        DSBE_ZFLAG_RST   = 1'b0;
endpackage

// [testbench/dsbe_rf_model.sv]
// data register file model seen by the execute stage
// assumes one clock; read is combinational, write lands on rf_we
`timescale 1ns/10ps
module dsbe_rf_model
  import dsbe_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic [DSBE_AW-1:0] rf_raddr,
  input  wire logic               rf_we,
  input  wire logic [DSBE_AW-1:0] rf_waddr,
  input  wire logic [DSBE_DW-1:0] rf_wdata,
  output logic      [DSBE_DW-1:0] rf_rdata
);
  logic [DSBE_DW-1:0] mem [2**DSBE_AW];
  // start value is the low nibble, so several cells hold one or zero
  initial
  begin
    for (int i = 0; i < 2**DSBE_AW; i++)
      mem[i] = 8'(i % 16);
  end
  assign rf_rdata = mem[rf_raddr];
  always @(posedge ref_clk)
  begin
    if (rf_we)
      mem[rf_waddr] <= rf_wdata;
  end
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the decrement / skip / branch execute block
// assumes the register file model starts each cell at its low nibble
`timescale 1ns/10ps
module tb_top;
  import dsbe_pkg::*;
  typedef struct packed {
    logic [13:0] ins;
    logic [7:0]  lat;
    logic [7:0]  acc;
    logic        z;
    logic        we;
    logic [7:0]  wd;
    logic        pl;
    logic [12:0] pt;
    logic        fl;
  } dsbe_row_s;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0]  program_counter_high_latch = 8'h00, rf_rdata, acc, rf_wdata;
  logic [6:0]  rf_raddr, rf_waddr;
  logic [12:0] pc_target;
  logic        rf_we, zero_flag, pc_load, flush, busy;
  int          fail_count = 0, cmp_count = 0, cyc = 0;
  dsbe_row_s   rows [10] = '{
    '{14'h0305, 8'h00, 8'h04, 1'b0, 1'b0, 8'h00, 1'b0, 13'h0000, 1'b0},
    '{14'h0381, 8'h00, 8'h04, 1'b1, 1'b1, 8'h00, 1'b0, 13'h0000, 1'b0},
    '{14'h0390, 8'h00, 8'h04, 1'b0, 1'b1, 8'hFF, 1'b0, 13'h0000, 1'b0},
    '{14'h0B09, 8'h00, 8'h08, 1'b0, 1'b0, 8'h00, 1'b0, 13'h0000, 1'b0},
    '{14'h0B91, 8'h00, 8'h08, 1'b0, 1'b1, 8'h00, 1'b0, 13'h0000, 1'b1},
    '{14'h0321, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 13'h0000, 1'b0},
    '{14'h0B31, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 13'h0000, 1'b1},
    '{14'h2FFF, 8'h18, 8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 13'h1FFF, 1'b1},
    '{14'h2923, 8'hE7, 8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 13'h0123, 1'b1},
    '{14'h3FFF, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 13'h0123, 1'b0}};
  dsbe_exec i_dut (
    .ref_clk                    (ref_clk),
    .sys_rst                    (sys_rst),
    .instr_valid                (instr_valid),
    .instr                      (instr),
    .program_counter_high_latch (program_counter_high_latch),
    .rf_rdata                   (rf_rdata),
    .rf_raddr                   (rf_raddr),
    .rf_we                      (rf_we),
    .rf_waddr                   (rf_waddr),
    .rf_wdata                   (rf_wdata),
    .acc                        (acc),
    .zero_flag                  (zero_flag),
    .pc_load                    (pc_load),
    .pc_target                  (pc_target),
    .flush                      (flush),
    .busy                       (busy)
  );
  dsbe_rf_model i_rf (
    .ref_clk  (ref_clk),
    .rf_raddr (rf_raddr),
    .rf_we    (rf_we),
    .rf_waddr (rf_waddr),
    .rf_wdata (rf_wdata),
    .rf_rdata (rf_rdata)
  );
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a run-away bench counts as a mismatch
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  // one word per row, then an idle slot that absorbs any flush
  initial
  begin
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("reset acc", 16'(DSBE_ACC_RST), 16'(acc));
    chk("reset flush", 16'h0000, 16'({flush, pc_load, rf_we, zero_flag}));
    $display("reset test done");
    foreach (rows[i])
    begin
      @(negedge ref_clk);
      instr_valid = 1'b1;
      instr = rows[i].ins;
      program_counter_high_latch = rows[i].lat;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      chk("acc", 16'(rows[i].acc), 16'(acc));
      chk("zero_flag", 16'(rows[i].z), 16'(zero_flag));
      chk("rf_we", 16'(rows[i].we), 16'(rf_we));
      if (rows[i].we)
        chk("rf_wdata", 16'(rows[i].wd), 16'(rf_wdata));
      if (rows[i].we)
        chk("rf_waddr", 16'(rows[i].ins[6:0]), 16'(rf_waddr));
      chk("pc_load", 16'(rows[i].pl), 16'(pc_load));
      chk("pc_target", 16'(rows[i].pt), 16'(pc_target));
      chk("flush", 16'({2{rows[i].fl}}), 16'({flush, busy}));
      $display("row %0d done", i);
    end
    // a word offered in the flushed slot after a branch must be dropped
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr = 14'h2ABC;
    program_counter_high_latch = 8'h08;
    @(negedge ref_clk);
    instr = 14'h0305;
    chk("pc_target", 16'h0ABC, 16'(pc_target));
    chk("branch pulse", 16'h0003, 16'({flush, pc_load}));
    @(negedge ref_clk);
    instr_valid = 1'b0;
    chk("acc", 16'h0000, 16'(acc));
    chk("flush end", 16'h0000, 16'({flush, pc_load}));
    $display("flushed slot test done");
    // reset in the bubble after a branch must clear pc_target, flush, pc_load, rf_we and zero_flag
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr = 14'h2FFF;
    program_counter_high_latch = 8'h18;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    sys_rst = 1'b1;
    @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("reset pc_target", 16'(DSBE_PC_RST), 16'(pc_target));
    chk("reset flags", 16'h0000, 16'({flush, pc_load, rf_we, zero_flag}));
    // the first word right after release must be taken
    instr_valid = 1'b1;
    instr = 14'h0305;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    chk("acc after reset", 16'h0004, 16'(acc));
    $display("mid-run reset test done");
    // back-to-back decrements of one register must chain their results
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr = 14'h0382;
    @(negedge ref_clk);
    instr = 14'h0302;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    chk("acc chained", 16'h0000, 16'(acc));
    chk("zero_flag chained", 16'h0001, 16'(zero_flag));
    $display("back-to-back test done");
    report_and_stop;
  end
endmodule
